/* src/sipo_host.sv */
// Purpose: Host end: shifts a word out, pulses the strobe, reads the chain back
// Assumes: User side on sys_clk_i; link clock made here by a divider
// Notes: Link clock is parked low outside a transfer
`timescale 1ns/1ns
`default_nettype none
module sipo_host
  import sipo_pkg::*;
#(
  parameter int CHAIN_BITS = SIPO_WIDTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic load_valid_i,
  input wire logic [CHAIN_BITS-1:0] load_data_i,
  output logic load_ready_o,
  input wire logic clear_i,
  output logic done_o,
  output logic [CHAIN_BITS-1:0] readback_o,
  sipo_link_if.host link
);
  localparam int BIT_W = $clog2(CHAIN_BITS + 1);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(CHAIN_BITS - 1);

  sipo_state_t state_q, state_d;
  logic [TIMER_W-1:0] cnt_q, cnt_d;
  logic [BIT_W-1:0] bit_q, bit_d;
  logic [CHAIN_BITS-1:0] tx_q, tx_d;
  logic [CHAIN_BITS-1:0] rx_q, rx_d;
  logic [CHAIN_BITS-1:0] rb_q, rb_d;
  logic sclk_q, sclk_d;
  logic sdata_q, sdata_d;
  logic stb_n_q, stb_n_d;
  logic clr_n_q, clr_n_d;
  logic done_q, done_d;
  logic ret_s;

  // Cascade return comes from the far clock domain
  sipo_sync u_ret_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(link.serial_out),
    .q_o(ret_s)
  );

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    rb_d = rb_q;
    sclk_d = sclk_q;
    sdata_d = sdata_q;
    stb_n_d = stb_n_q;
    done_d = 1'b0;
    clr_n_d = ~clear_i;
    unique case (state_q)
      SIPO_IDLE:
      begin
        if (load_valid_i)
        begin
          tx_d = load_data_i;
          sdata_d = load_data_i[CHAIN_BITS-1];
          bit_d = '0;
          cnt_d = TIMER_RELOAD;
          state_d = SIPO_LOW;
        end
      end
      SIPO_LOW:
      begin
        if (cnt_q == TIMER_ZERO)
        begin
          sclk_d = 1'b1;
          rx_d = {rx_q[CHAIN_BITS-2:0], ret_s};
          cnt_d = TIMER_RELOAD;
          state_d = SIPO_HIGH;
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      SIPO_HIGH:
      begin
        if (cnt_q == TIMER_ZERO)
        begin
          sclk_d = LINK_IDLE_CLK;
          cnt_d = TIMER_RELOAD;
          tx_d = {tx_q[CHAIN_BITS-2:0], 1'b0};
          if (bit_q == LAST_BIT)
          begin
            // Clock is parked on the same edge that the strobe drops
            stb_n_d = 1'b0;
            state_d = SIPO_STB;
          end
          else
          begin
            bit_d = bit_q + 1'b1;
            sdata_d = tx_q[CHAIN_BITS-2];
            state_d = SIPO_LOW;
          end
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      SIPO_STB:
      begin
        if (cnt_q == TIMER_ZERO)
        begin
          stb_n_d = STROBE_IDLE;
          cnt_d = TIMER_RELOAD;
          state_d = SIPO_GAP;
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      SIPO_GAP:
      begin
        // Strobe-to-clock setup before another word may start
        if (cnt_q == TIMER_ZERO)
        begin
          rb_d = rx_q;
          done_d = 1'b1;
          state_d = SIPO_IDLE;
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default:
      begin
        state_d = SIPO_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= SIPO_IDLE;
      cnt_q <= TIMER_ZERO;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      rb_q <= '0;
      sclk_q <= LINK_IDLE_CLK;
      sdata_q <= 1'b0;
      stb_n_q <= STROBE_IDLE;
      clr_n_q <= CLEAR_IDLE;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      rb_q <= rb_d;
      sclk_q <= sclk_d;
      sdata_q <= sdata_d;
      stb_n_q <= stb_n_d;
      clr_n_q <= clr_n_d;
      done_q <= done_d;
    end
  end

  assign load_ready_o = (state_q == SIPO_IDLE);
  assign done_o = done_q;
  assign readback_o = rb_q;
  assign link.link_clk = sclk_q;
  assign link.serial_data = sdata_q;
  assign link.latch_strobe_n = stb_n_q;
  assign link.clear_n = clr_n_q;
endmodule
`default_nettype wire

/* src/sipo_pkg.sv */
// Purpose: Shared constants for the serial-in parallel-out expander ends
// Assumes: Host runs on a 125 MHz system clock
// Notes: Link timing counts derive from the link rate ceiling
`default_nettype none
package sipo_pkg;
  localparam int SIPO_WIDTH = 20;
  localparam int SYS_CLK_PERIOD_NS = 8;
  localparam int LINK_MAX_FREQ_MHZ = 5;
  localparam int LINK_MIN_PERIOD_NS = 1000 / LINK_MAX_FREQ_MHZ;
  // Least half period, rounded up to whole system cycles
  localparam int LINK_HALF_CYC =
    ((LINK_MIN_PERIOD_NS / 2) + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int TIMER_W = 8;
  localparam logic [TIMER_W-1:0] TIMER_RELOAD = TIMER_W'(LINK_HALF_CYC - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 8'h00;
  localparam logic LINK_IDLE_CLK = 1'b0;
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic CLEAR_IDLE = 1'b1;

  typedef enum logic [4:0] {
    SIPO_IDLE = 5'b00001,
    SIPO_LOW = 5'b00010,
    SIPO_HIGH = 5'b00100,
    SIPO_STB = 5'b01000,
    SIPO_GAP = 5'b10000
  } sipo_state_t;
endpackage
`default_nettype wire

/* src/sipo_link_if.sv */
// Purpose: Four-wire serial link plus cascade return between host and expander
// Assumes: Host drives the link clock, strobe, clear and data
// Notes: Strobe and clear are active low
`timescale 1ns/1ns
`default_nettype none
interface sipo_link_if;
  logic link_clk;
  logic serial_data;
  logic latch_strobe_n;
  logic clear_n;
  logic serial_out;

  modport host (
    output link_clk,
    output serial_data,
    output latch_strobe_n,
    output clear_n,
    input serial_out
  );

  modport dev (
    input link_clk,
    input serial_data,
    input latch_strobe_n,
    input clear_n,
    output serial_out
  );
endinterface
`default_nettype wire

/* src/sipo_dev.sv */
// Purpose: Expander end: shift register, output latch bank, cascade output
// Assumes: Host stops the link clock while the strobe is low
// Notes: Shift register has no reset; it is unknown until filled by shifts
//
// Contract
// - Twenty-bit shift register and latch bank
// - Clear low forces all latches and outputs low
// - Clear leaves shift register untouched
// - Rising link clock shifts data into stage one
// - Strobe high: latches hold while register shifts
// - Strobe falling copies register into latches
// - Latch bits drive parallel outputs one-to-one
// - Strobe low: latches follow register transparently
// - Host stops clock while strobe held low
// - Last stage drives serial out always
// - Serial out may feed next device's input
// - Host keeps link clock within rate ceiling
// - Host keeps clear high in normal use
`timescale 1ns/1ns
`default_nettype none
module sipo_dev
  import sipo_pkg::*;
#(
  parameter int WIDTH = SIPO_WIDTH
) (
  sipo_link_if.dev link,
  output logic [WIDTH-1:0] parallel_out_o
);
  logic [WIDTH-1:0] shift_q;
  logic [WIDTH-1:0] shift_d;
  logic [WIDTH-1:0] hold_q;
  logic [WIDTH-1:0] hold_d;

  // Stage 0 takes the pin; the oldest bit sits in the top stage
  always_comb
  begin
    shift_d = {shift_q[WIDTH-2:0], link.serial_data};
  end

  // Clear is deliberately not a reset here
  always_ff @(posedge link.link_clk)
  begin
    shift_q <= shift_d;
  end

  // Latch bank closes on the strobe's rising edge; while it is open the
  // output mux below shows the register itself, which models transparency
  always_comb
  begin
    hold_d = shift_q;
  end

  always_ff @(posedge link.latch_strobe_n or negedge link.clear_n)
  begin
    if (!link.clear_n)
    begin
      hold_q <= '0;
    end
    else
    begin
      hold_q <= hold_d;
    end
  end

  always_comb
  begin
    if (!link.clear_n)
    begin
      parallel_out_o = '0;
    end
    else if (!link.latch_strobe_n)
    begin
      parallel_out_o = shift_q;
    end
    else
    begin
      parallel_out_o = hold_q;
    end
  end

  // Independent of clear and strobe, so a chain keeps shifting
  assign link.serial_out = shift_q[WIDTH-1];
endmodule
`default_nettype wire

/* src/sipo_sync.sv */
// Purpose: Two-flop synchroniser for one level into the system clock
// Assumes: Input is a slow level
// Notes: Only the second flop may be read
`timescale 1ns/1ns
`default_nettype none
module sipo_sync (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

/* dv/sipo_link_sva.sv */
// Purpose: Link and output checks for the expander pair
// Assumes: Host end makes the link clock from sys_clk_i
// Notes: Hold check waits for the first clear, outputs are unknown before
`timescale 1ns/1ns
`default_nettype none
module sipo_link_sva
  import sipo_pkg::*;
#(
  parameter int WIDTH = SIPO_WIDTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk,
  input wire logic serial_data,
  input wire logic latch_strobe_n,
  input wire logic clear_n,
  input wire logic serial_out,
  input wire logic [WIDTH-1:0] parallel_out_o
);
  logic [5:0] edges_q;
  logic [5:0] edges_d;
  logic [7:0] stay_q;
  logic [7:0] stay_d;
  logic link_q;
  logic armed_q;
  logic armed_d;
  always_comb
  begin
    edges_d = (edges_q == 6'h3f) ? edges_q : edges_q + 6'h01;
    stay_d = (link_clk != link_q) ? 8'h00 : ((stay_q == 8'hff) ? stay_q : stay_q + 8'h01);
    armed_d = armed_q | !clear_n;
  end
  always_ff @(posedge link_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
      edges_q <= 6'h00;
    else
      edges_q <= edges_d;
  end
  always_ff @(posedge sys_clk_i)
  begin
    link_q <= rst_n_i ? link_clk : 1'b0;
    stay_q <= rst_n_i ? stay_d : 8'hff;
    armed_q <= rst_n_i ? armed_d : 1'b0;
  end
  chk_clear_zeroes_out:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !clear_n |-> parallel_out_o == '0) else $error("outputs not low under clear");
  chk_latch_holds:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    armed_q && latch_strobe_n && clear_n && $past(latch_strobe_n) && $past(clear_n)
    |-> $stable(parallel_out_o)) else $error("latched outputs moved");
  // Stage 0 must hold the last bit sent, which still stands on the data pin
  chk_strobe_copies:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(latch_strobe_n) && clear_n
    |-> parallel_out_o[WIDTH-1] == serial_out && parallel_out_o[0] == serial_data)
    else $error("strobe did not load the register ends");
  chk_strobe_transparent:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !latch_strobe_n && clear_n
    |-> parallel_out_o[WIDTH-1] == serial_out && parallel_out_o[0] == serial_data)
    else $error("outputs not tracking register");
  chk_tail_path:
  assert property (@(posedge link_clk) disable iff (!rst_n_i)
    edges_q >= 6'(WIDTH) |-> serial_out == $past(serial_data, WIDTH))
    else $error("serial out not the data of twenty edges ago");
  chk_link_rate:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    link_clk != link_q |-> stay_q >= LINK_HALF_CYC - 1) else $error("link half period short");
  chk_strobe_clk_low:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $changed(latch_strobe_n) |-> !link_clk) else $error("strobe moved with clock high");
  chk_clk_parked:
  assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !latch_strobe_n |-> !link_clk [*2]) else $error("link clock ran under strobe");
  cov_strobe: cover property (@(posedge sys_clk_i) $fell(latch_strobe_n));
  cov_clear: cover property (@(posedge sys_clk_i) $fell(clear_n));
  cov_full: cover property (@(posedge link_clk) edges_q >= 6'(WIDTH));
endmodule
`default_nettype wire

/* dv/serial_in_parallel_out_expander_tb.sv */
// Purpose: Host and expander joined, word loads checked at the outputs
// Assumes: One expander, host chain as wide as the expander
// Notes: Each load after the first returns the previous word on readback
`timescale 1ns/1ns
`default_nettype none
module serial_in_parallel_out_expander_tb
  import sipo_pkg::*;
;
  logic sys_clk_i;
  logic rst_n_i;
  logic load_valid_i;
  logic [SIPO_WIDTH-1:0] load_data_i;
  logic load_ready_o;
  logic clear_i;
  logic done_o;
  logic [SIPO_WIDTH-1:0] readback_o;
  logic [SIPO_WIDTH-1:0] parallel_out_o;
  logic [SIPO_WIDTH-1:0] words [4];
  // Take edge to done: one cycle, two half periods a bit, strobe, gap
  localparam int HELD_WAIT = 200;
  localparam int LOAD_CYC = 1 + 2 * LINK_HALF_CYC * SIPO_WIDTH + 2 * LINK_HALF_CYC;
  int n_errors;
  int samples_checked;
  sipo_link_if u_sipo_link_if();
  sipo_host #(.CHAIN_BITS(SIPO_WIDTH)) u_sipo_host (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .load_valid_i(load_valid_i), .load_data_i(load_data_i), .load_ready_o(load_ready_o),
    .clear_i(clear_i), .done_o(done_o), .readback_o(readback_o), .link(u_sipo_link_if.host));
  sipo_dev #(.WIDTH(SIPO_WIDTH)) u_sipo_dev (.link(u_sipo_link_if.dev),
    .parallel_out_o(parallel_out_o));
  sipo_link_sva #(.WIDTH(SIPO_WIDTH)) u_sipo_link_sva (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .link_clk(u_sipo_link_if.link_clk),
    .serial_data(u_sipo_link_if.serial_data), .latch_strobe_n(u_sipo_link_if.latch_strobe_n),
    .clear_n(u_sipo_link_if.clear_n), .serial_out(u_sipo_link_if.serial_out),
    .parallel_out_o(parallel_out_o));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string what, input logic [SIPO_WIDTH-1:0] exp,
    input logic [SIPO_WIDTH-1:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_int(input string what, input int exp, input int got);
    samples_checked++;
    if (got != exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic pulse_clear();
    @(negedge sys_clk_i);
    clear_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk("cleared", '0, parallel_out_o);
    clear_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
  endtask
  task automatic load_word(input logic [SIPO_WIDTH-1:0] w, input logic [SIPO_WIDTH-1:0] prev);
    int t;
    t = 0;
    @(negedge sys_clk_i);
    load_valid_i = 1'b1;
    load_data_i = w;
    @(negedge sys_clk_i);
    load_valid_i = 1'b0;
    // Mid-shift, latches must still show the old word
    repeat (HELD_WAIT) @(negedge sys_clk_i);
    chk("held", prev, parallel_out_o);
    chk_bit("busy", 1'b0, load_ready_o);
    while (done_o !== 1'b1 && t < 1000)
    begin
      @(negedge sys_clk_i);
      t++;
    end
    if (t >= 1000)
      n_errors++;
    chk_int("load cycles", LOAD_CYC, t + HELD_WAIT + 1);
  endtask
  initial
  begin
    logic [SIPO_WIDTH-1:0] prev;
    words = '{20'ha5c3e, 20'h80001, 20'hfffff, 20'h00000};
    n_errors = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    load_valid_i = 1'b0;
    load_data_i = '0;
    clear_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    pulse_clear();
    prev = '0;
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2)
      begin
        pulse_clear();
        prev = '0;
      end
      load_word(words[i], prev);
      chk("parallel", words[i], parallel_out_o);
      if (i > 0)
        chk("readback", words[i-1], readback_o);
      prev = words[i];
      $display("load test %0d over", i);
    end
    stop_test();
  end
  initial
  begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
